// ### tcr_pkg.sv
package tcr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CAP_W = 12;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] CAPA_OFF = 8'h20;
  localparam logic [7:0] CAPB_OFF = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SWA_BIT = 0;
  localparam int CTRL_SWB_BIT = 1;
  localparam int CTRL_HWA_BIT = 8;
  localparam int CTRL_HWB_BIT = 9;
  localparam int STAT_LOCKA_BIT = 0;
  localparam int STAT_LOCKB_BIT = 1;
  localparam int STAT_PENDA_BIT = 2;
  localparam int STAT_PENDB_BIT = 3;
  localparam int STAT_OVRA_BIT = 4;
  localparam int STAT_OVRB_BIT = 5;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [11:0] CAP_RST = 12'h000;
  localparam logic HW_EN_RST = 1'b1;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // word-aligned address match
  function automatic logic hitWord(input logic [7:0] addr, input logic [7:0] off);
    hitWord = (addr[7:2] == off[7:2]);
  endfunction

endpackage

// ### tcr_axil_slave.sv
`timescale 1ns/1ps
module tcr_axil_slave (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wrEn,
  output logic [7:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrOk,
  output logic rdEn,
  output logic [7:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdOk
);

  typedef struct packed {
    logic awRdy;
    logic awHeld;
    logic [7:0] awAddr;
    logic wRdy;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } tcr_axil_state_t;

  tcr_axil_state_t s_q;
  tcr_axil_state_t s_d;

  always_comb begin
    s_d = s_q;
    wrEn = 1'b0;
    rdEn = 1'b0;
    if (s_axi_awvalid && s_q.awRdy) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wRdy) begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    // address and data may arrive in either order; commit once both held
    if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
      wrEn = 1'b1;
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = wrOk ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
    end
    s_d.awRdy = !s_d.awHeld;
    s_d.wRdy = !s_d.wHeld;
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arRdy) begin
      rdEn = 1'b1;
      s_d.rValid = 1'b1;
      s_d.rData = rdData;
      s_d.rResp = rdOk ? tcr_pkg::RESP_OKAY : tcr_pkg::RESP_SLVERR;
    end
    s_d.arRdy = !s_d.rValid;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wrAddr = s_q.awAddr;
  assign wrData = s_q.wData;
  assign wrStrb = s_q.wStrb;
  assign rdAddr = s_axi_araddr;
  assign s_axi_awready = s_q.awRdy;
  assign s_axi_wready = s_q.wRdy;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = s_q.arRdy;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

endmodule

// ### tcr_capture_stage.sv
`timescale 1ns/1ps
module tcr_capture_stage (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] counterValue,
  input wire logic trigger,
  input wire logic updateCond,
  input wire logic unlock,
  output logic [11:0] captureValue,
  output logic locked,
  output logic pending,
  output logic overrun
);

  typedef struct packed {
    logic [11:0] buffer;
    logic bufFull;
    logic [11:0] capture;
    logic locked;
  } tcr_cap_state_t;

  tcr_cap_state_t s_q;
  tcr_cap_state_t s_d;
  logic transfer;

  always_comb begin
    s_d = s_q;
    // blocked while software has not yet fetched the high byte
    transfer = updateCond && s_q.bufFull && !s_q.locked;
    if (transfer) begin
      s_d.capture = s_q.buffer;
      s_d.bufFull = 1'b0;
      s_d.locked = 1'b1;
    end else if (unlock) begin
      s_d.locked = 1'b0;
    end
    // newest trigger wins; a new count beats the buffer drain
    if (trigger) begin
      s_d.buffer = counterValue;
      s_d.bufFull = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{tcr_pkg::CAP_RST, 1'b0, tcr_pkg::CAP_RST, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign captureValue = s_q.capture;
  assign locked = s_q.locked;
  assign pending = s_q.bufFull;
  // a buffer drained at the same edge is not overwritten
  assign overrun = trigger && s_q.bufFull && !transfer;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  trig_loads_buf_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    trigger |=> (s_q.bufFull && s_q.buffer == $past(counterValue)))
    else $error("trigger did not load counter into buffer");

  update_moves_buf_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (updateCond && s_q.bufFull && !s_q.locked) |=> (s_q.locked && s_q.capture == $past(s_q.buffer)))
    else $error("update did not move buffer into capture register");

  cap_only_update_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !$stable(s_q.capture) |-> $past(updateCond))
    else $error("capture register changed without update");

  locked_holds_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (s_q.locked && !unlock) |=> (s_q.locked && $stable(s_q.capture)))
    else $error("locked capture register changed before release");

endmodule

// ### tcr_top.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module tcr_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] counterValue,
  input wire logic hwTrigA,
  input wire logic hwTrigB,
  input wire logic updateCond,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic swReqA;
    logic swReqB;
    logic hwEnA;
    logic hwEnB;
    logic ovrA;
    logic ovrB;
  } tcr_top_state_t;

  tcr_top_state_t s_q;
  tcr_top_state_t s_d;

  logic wrEn;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic rdEn;
  logic [7:0] rdAddr;
  logic [31:0] rdData;
  logic rdOk;

  logic trigA;
  logic trigB;
  logic relA;
  logic relB;
  logic [11:0] capA;
  logic [11:0] capB;
  logic lockA;
  logic lockB;
  logic pendA;
  logic pendB;
  logic ovrEvtA;
  logic ovrEvtB;
  logic rdFireB;
  logic wrCtrl;
  logic wrStat;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  tcr_axil_slave u_bus (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrOk(wrOk),
    .rdEn(rdEn),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdOk(rdOk)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // capture words accept writes silently; they are read-only
  assign wrOk = tcr_pkg::hitWord(wrAddr, tcr_pkg::CTRL_OFF)
             || tcr_pkg::hitWord(wrAddr, tcr_pkg::STAT_OFF)
             || tcr_pkg::hitWord(wrAddr, tcr_pkg::CAPA_OFF)
             || tcr_pkg::hitWord(wrAddr, tcr_pkg::CAPB_OFF);
  assign rdOk = tcr_pkg::hitWord(rdAddr, tcr_pkg::CTRL_OFF)
             || tcr_pkg::hitWord(rdAddr, tcr_pkg::STAT_OFF)
             || tcr_pkg::hitWord(rdAddr, tcr_pkg::CAPA_OFF)
             || tcr_pkg::hitWord(rdAddr, tcr_pkg::CAPB_OFF);
  assign wrCtrl = wrEn && tcr_pkg::hitWord(wrAddr, tcr_pkg::CTRL_OFF);
  assign wrStat = wrEn && tcr_pkg::hitWord(wrAddr, tcr_pkg::STAT_OFF);

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // low byte in lane 0, high byte in lane 1 (next byte address)
  always_comb begin
    rdData = 32'h0000_0000;
    if (tcr_pkg::hitWord(rdAddr, tcr_pkg::CTRL_OFF)) begin
      rdData[tcr_pkg::CTRL_HWA_BIT] = s_q.hwEnA;
      rdData[tcr_pkg::CTRL_HWB_BIT] = s_q.hwEnB;
    end else if (tcr_pkg::hitWord(rdAddr, tcr_pkg::STAT_OFF)) begin
      rdData[tcr_pkg::STAT_LOCKA_BIT] = lockA;
      rdData[tcr_pkg::STAT_LOCKB_BIT] = lockB;
      rdData[tcr_pkg::STAT_PENDA_BIT] = pendA;
      rdData[tcr_pkg::STAT_PENDB_BIT] = pendB;
      rdData[tcr_pkg::STAT_OVRA_BIT] = s_q.ovrA;
      rdData[tcr_pkg::STAT_OVRB_BIT] = s_q.ovrB;
    end else if (tcr_pkg::hitWord(rdAddr, tcr_pkg::CAPA_OFF)) begin
      rdData[11:0] = capA;
    end else if (tcr_pkg::hitWord(rdAddr, tcr_pkg::CAPB_OFF)) begin
      rdData[11:0] = capB;
    end
  end

  // a word read always carries the high byte, so any read of a capture word releases that channel
  assign rdFireB = rdEn && tcr_pkg::hitWord(rdAddr, tcr_pkg::CAPB_OFF);
  assign relA = rdEn && tcr_pkg::hitWord(rdAddr, tcr_pkg::CAPA_OFF);
  assign relB = rdFireB;

  // ----------------------------------------------------------------
  // capture sources
  // ----------------------------------------------------------------
  // event source gated by its enable, software source always honoured
  assign trigA = (hwTrigA && s_q.hwEnA) || s_q.swReqA;
  assign trigB = (hwTrigB && s_q.hwEnB) || s_q.swReqB;

  tcr_capture_stage u_capA (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .counterValue(counterValue),
    .trigger(trigA),
    .updateCond(updateCond),
    .unlock(relA),
    .captureValue(capA),
    .locked(lockA),
    .pending(pendA),
    .overrun(ovrEvtA)
  );

  tcr_capture_stage u_capB (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .counterValue(counterValue),
    .trigger(trigB),
    .updateCond(updateCond),
    .unlock(relB),
    .captureValue(capB),
    .locked(lockB),
    .pending(pendB),
    .overrun(ovrEvtB)
  );

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.swReqA = 1'b0;
    s_d.swReqB = 1'b0;
    if (wrCtrl && wrStrb[0]) begin
      s_d.swReqA = wrData[tcr_pkg::CTRL_SWA_BIT];
      s_d.swReqB = wrData[tcr_pkg::CTRL_SWB_BIT];
    end
    if (wrCtrl && wrStrb[1]) begin
      s_d.hwEnA = wrData[tcr_pkg::CTRL_HWA_BIT];
      s_d.hwEnB = wrData[tcr_pkg::CTRL_HWB_BIT];
    end
    if (wrStat && wrStrb[0]) begin
      if (wrData[tcr_pkg::STAT_OVRA_BIT]) begin
        s_d.ovrA = 1'b0;
      end
      if (wrData[tcr_pkg::STAT_OVRB_BIT]) begin
        s_d.ovrB = 1'b0;
      end
    end
    // set after clear so a same-cycle event is kept
    if (ovrEvtA) begin
      s_d.ovrA = 1'b1;
    end
    if (ovrEvtB) begin
      s_d.ovrB = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{1'b0, 1'b0, tcr_pkg::HW_EN_RST, tcr_pkg::HW_EN_RST, 1'b0, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sw_req_capture_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (wrCtrl && wrStrb[0] && wrData[tcr_pkg::CTRL_SWB_BIT])
      |=> ##1 (pendB || lockB))
    else $error("software capture request did not reach capture path");

  hw_trig_capture_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (hwTrigB && s_q.hwEnB) |=> pendB)
    else $error("hardware trigger did not fill capture buffer");

  hw_gate_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!pendB && hwTrigB && !s_q.hwEnB && !s_q.swReqB) |=> !pendB)
    else $error("disabled event source still captured");

  high_read_release_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (rdFireB && lockB) |=> !lockB)
    else $error("high byte read did not release capture register");

  no_release_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (lockB && !rdFireB) |=> $stable(capB))
    else $error("capture value overwritten while not yet read");

  read_value_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    rdFireB |=> (s_axi_rvalid && s_axi_rdata[11:0] == $past(capB)))
    else $error("read returned wrong capture value");

  upper_bits_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    rdFireB |=> (s_axi_rdata[31:12] == 20'h00000 && s_axi_rresp == tcr_pkg::RESP_OKAY))
    else $error("unused capture bits not zero");

  byte_lane_order_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    rdFireB |=> (s_axi_rdata[15:8] == {4'h0, $past(capB[11:8])}
                 && s_axi_rdata[7:0] == $past(capB[7:0])))
    else $error("capture bytes not in low then high lanes");

  update_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (!updateCond && !lockB) |=> !lockB)
    else $error("capture register loaded without update condition");

  ovr_set_wins_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ovrEvtB |=> s_q.ovrB)
    else $error("overrun event lost");

endmodule

// ### tcr_top_test.sv
`timescale 1ns/1ps
module tcr_top_test;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk;
  logic rst_b;
  logic [11:0] counterValue;
  logic hwTrigA;
  logic hwTrigB;
  logic updateCond;
  logic [7:0] awAddr;
  logic awValid;
  logic awReady;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wValid;
  logic wReady;
  logic [1:0] bResp;
  logic bValid;
  logic bReady;
  logic [7:0] arAddr;
  logic arValid;
  logic arReady;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic rValid;
  logic rReady;
  int errorCnt;
  int nTests;
  int cycleCnt;

  tcr_top dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .counterValue(counterValue),
    .hwTrigA(hwTrigA),
    .hwTrigB(hwTrigB),
    .updateCond(updateCond),
    .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid),
    .s_axi_awready(awReady),
    .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid),
    .s_axi_wready(wReady),
    .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid),
    .s_axi_bready(bReady),
    .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid),
    .s_axi_arready(arReady),
    .s_axi_rdata(rData),
    .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid),
    .s_axi_rready(rReady)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // report and timeout
  // ----------------------------------------------------------------
  task automatic testDone;
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 5000) begin
      errorCnt = errorCnt + 1;
      testDone();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    resp = 2'h3;
    // the wait ends at bvalid; only the bench timeout ends it if no response comes
    while (!done) begin
      @(posedge core_clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid) begin
        resp = bResp;
        bReady <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic readChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                         input string name);
    logic [31:0] d;
    logic [1:0] r;
    logic done;
    d = 32'hdead_beef;
    r = 2'h3;
    done = 1'b0;
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid) begin
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        done = 1'b1;
      end
    end
    check(name, d, exp);
    check("read response", {30'h0, r}, {30'h0, er});
  endtask

  // sel bits: update, trigger B, trigger A; count moves away afterwards
  task automatic pulse(input logic [2:0] sel, input logic [11:0] cnt);
    @(posedge core_clk);
    {updateCond, hwTrigB, hwTrigA} <= sel;
    counterValue <= cnt;
    @(posedge core_clk);
    {updateCond, hwTrigB, hwTrigA} <= 3'h0;
    counterValue <= ~cnt;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  localparam logic [31:0] LOCKB = 32'h1 << tcr_pkg::STAT_LOCKB_BIT;
  localparam logic [31:0] PENDB = 32'h1 << tcr_pkg::STAT_PENDB_BIT;
  localparam logic [31:0] OVRB = 32'h1 << tcr_pkg::STAT_OVRB_BIT;
  localparam logic [31:0] HWEN = (32'h1 << tcr_pkg::CTRL_HWA_BIT) | (32'h1 << tcr_pkg::CTRL_HWB_BIT);

  task automatic resetValues;
    readChk(tcr_pkg::CAPB_OFF, 32'h0, tcr_pkg::RESP_OKAY, "second capture");
    readChk(tcr_pkg::CAPA_OFF, 32'h0, tcr_pkg::RESP_OKAY, "first capture");
    readChk(tcr_pkg::STAT_OFF, 32'h0, tcr_pkg::RESP_OKAY, "status");
    readChk(tcr_pkg::CTRL_OFF, HWEN, tcr_pkg::RESP_OKAY, "control");
  endtask

  task automatic hwCapture;
    pulse(3'h2, 12'habc);
    readChk(tcr_pkg::STAT_OFF, PENDB, tcr_pkg::RESP_OKAY, "status pending");
    pulse(3'h4, 12'h000);
    readChk(tcr_pkg::STAT_OFF, LOCKB, tcr_pkg::RESP_OKAY, "status locked");
    // low byte bc at lane 0, high nibble 0a at lane 1
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_0abc, tcr_pkg::RESP_OKAY, "capture hw");
  endtask

  task automatic lockHold;
    pulse(3'h2, 12'h123);
    pulse(3'h4, 12'h000);
    pulse(3'h2, 12'h456);
    pulse(3'h4, 12'h000);
    readChk(tcr_pkg::STAT_OFF, LOCKB | PENDB, tcr_pkg::RESP_OKAY, "status held");
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_0123, tcr_pkg::RESP_OKAY, "capture held");
    pulse(3'h4, 12'h000);
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_0456, tcr_pkg::RESP_OKAY, "capture freed");
  endtask

  task automatic swCapture;
    logic [1:0] r;
    @(posedge core_clk);
    counterValue <= 12'h7e5;
    axiWrite(tcr_pkg::CTRL_OFF, 32'h2, 4'h1, r);
    check("control write", {30'h0, r}, {30'h0, tcr_pkg::RESP_OKAY});
    pulse(3'h4, 12'h7e5);
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_07e5, tcr_pkg::RESP_OKAY, "capture sw");
    axiWrite(tcr_pkg::CTRL_OFF, 32'h0, 4'h2, r);
    readChk(tcr_pkg::CTRL_OFF, 32'h0, tcr_pkg::RESP_OKAY, "control off");
    pulse(3'h2, 12'h111);
    pulse(3'h4, 12'h000);
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_07e5, tcr_pkg::RESP_OKAY, "capture off");
    axiWrite(tcr_pkg::CTRL_OFF, HWEN, 4'h2, r);
  endtask

  task automatic readOnly;
    logic [1:0] r;
    axiWrite(tcr_pkg::CAPB_OFF, 32'h0000_0fff, 4'hf, r);
    check("capture write", {30'h0, r}, {30'h0, tcr_pkg::RESP_OKAY});
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_07e5, tcr_pkg::RESP_OKAY, "capture ro");
    axiWrite(8'h40, 32'h1, 4'hf, r);
    check("unmapped write", {30'h0, r}, {30'h0, tcr_pkg::RESP_SLVERR});
    readChk(8'h40, 32'h0, tcr_pkg::RESP_SLVERR, "unmapped read");
  endtask

  task automatic firstPath;
    pulse(3'h1, 12'h9c3);
    pulse(3'h4, 12'h000);
    readChk(tcr_pkg::CAPA_OFF, 32'h0000_09c3, tcr_pkg::RESP_OKAY, "first path");
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_07e5, tcr_pkg::RESP_OKAY, "second kept");
  endtask

  // second trigger on a full buffer: newest count kept, overrun flagged
  task automatic overrunClear;
    logic [1:0] r;
    pulse(3'h2, 12'h321);
    pulse(3'h2, 12'h654);
    readChk(tcr_pkg::STAT_OFF, PENDB | OVRB, tcr_pkg::RESP_OKAY, "status overrun");
    axiWrite(tcr_pkg::STAT_OFF, OVRB, 4'h1, r);
    check("status write", {30'h0, r}, {30'h0, tcr_pkg::RESP_OKAY});
    readChk(tcr_pkg::STAT_OFF, PENDB, tcr_pkg::RESP_OKAY, "status cleared");
    pulse(3'h4, 12'h000);
    readChk(tcr_pkg::CAPB_OFF, 32'h0000_0654, tcr_pkg::RESP_OKAY, "capture newest");
    @(posedge core_clk);
    counterValue <= 12'h5a5;
    axiWrite(tcr_pkg::CTRL_OFF, 32'h1, 4'h1, r);
    pulse(3'h4, 12'h5a5);
    readChk(tcr_pkg::CAPA_OFF, 32'h0000_05a5, tcr_pkg::RESP_OKAY, "first sw");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errorCnt = 0;
    nTests = 0;
    cycleCnt = 0;
    rst_b = 1'b0;
    counterValue = 12'h000;
    {hwTrigA, hwTrigB, updateCond} = 3'h0;
    {awAddr, arAddr} = 16'h0000;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    wData = 32'h0;
    wStrb = 4'h0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    resetValues();
    hwCapture();
    lockHold();
    swCapture();
    readOnly();
    firstPath();
    overrunClear();
    testDone();
  end

endmodule
